// [design/rdv_defs.vh]
`ifndef RDV_DEFS_VH
`define RDV_DEFS_VH
// register indices
`define RDV_REG_CTRL2    8'h02
`define RDV_REG_IRQMASK  8'h03
`define RDV_REG_IRQFLAG  8'h04
`define RDV_REG_STATUS   8'h05
`define RDV_REG_CTRL14   8'h0e
`define RDV_REG_CTRL16   8'h10
`define RDV_REG_CTRL17   8'h11
`define RDV_REG_CTRL18   8'h12
`define RDV_REG_MAXFREQ  8'h16
`define RDV_REG_CHECK    8'h17
`define RDV_REG_VALID    8'h18
// register indices chosen locally
`define RDV_REG_LINE     8'h40
`define RDV_REG_IRQCFG   8'h41
// field positions
`define RDV_BIT_BOTHEDGE 2
`define RDV_BIT_RINGIRQ  7
`define RDV_BIT_POSFLAG  0
`define RDV_BIT_NEGFLAG  1
`define RDV_BIT_ENVFLAG  2
`define RDV_BIT_ONHMON   3
`define RDV_BIT_INDPOL   1
`define RDV_BIT_THRLO    0
`define RDV_BIT_THRHI    4
`define RDV_BIT_FULLWAVE 1
`define RDV_BIT_VALIDEN  7
`define RDV_BIT_OFFHOOK  0
`define RDV_BIT_PWRDOWN  1
`define RDV_BIT_IRQPOL   0
// ring sample codes
`define RDV_SAMPLE_MAX   16'h7fff
`define RDV_SAMPLE_MIN   16'h8000
`define RDV_SAMPLE_MID   16'h04cc
// thresholds in adc codes for 15, 21 and 45 volts
`define RDV_THR_15V      16'h0f00
`define RDV_THR_21V      16'h1500
`define RDV_THR_45V      16'h2d00
// timing
`define RDV_CLK_HZ       40000000
`define RDV_TICK_US      1000
`define RDV_TICK_CYC     ((`RDV_CLK_HZ / 1000000) * `RDV_TICK_US)
`define RDV_ONESHOT_MS   5000
`define RDV_ONESHOT_TICK (`RDV_ONESHOT_MS * 1000 / `RDV_TICK_US)
`endif

// [design/rdv_ring_detect_validate.v]
// What this block does
// - full-wave bit 0 (default): only voltages above positive threshold count
// - full-wave bit 1: above positive or below negative threshold counts
// - indicator pin active low at reset, active high when polarity bit set
// - unvalidated indicator follows positive, or positive-or-negative, detection
// - positive/negative flags follow thresholds; neither between them
// - envelope flag is retriggerable one-shot of about five seconds
// - off-hook forces the envelope flag to zero
// - masked envelope trigger raises shared interrupt; host clears by writing flag
// - interrupt on envelope rise, or both edges with both-edge bit
// - ring data replaces audio when link up, on-hook, no monitor
// - half-wave samples: min between thresholds, max on positive ring
// - full-wave samples: +1228 between, max positive, min negative
// - sample msb toggles at ring frequency in both modes
// - validator times alternating crossings against low and high frequency limits
// - after check window, validator watches for ring-end timeout
// - delay timer must expire before ring end for valid ring
// - validation enable bit switches validation; sleep needs host clock
// - with validation, envelope status and interrupt show validated rings only
// - interrupt pin follows interrupt flag with configurable polarity
// - validated indicator: envelope if half-wave, plain one-shot if full-wave
// - two threshold select bits choose 15, 21 or 45 volt threshold
//
// The implementer's own choices: the line and interrupt configuration register indices and the strobed register port.
`timescale 1ns/1ps
`include "rdv_defs.vh"
module rdv_ring_detect_validate (
   // clock and reset
   input wire clk,
   input wire rstn,
   // register port
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [7:0] regRdata,
   // digitised ring voltage from the isolation link
   input wire [15:0] ringVoltage,
   input wire ringVoltageValid,
   // audio and transmit stream
   input wire [15:0] txAudio,
   output reg [15:0] txSampleOut,
   // open-drain ring indicator pin
   output reg ringIndicatorOut,
   output reg ringIndicatorOen,
   // shared interrupt pin
   output reg sharedIrqOut
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg bothEdgeIrq, ringIrqMask, ringIrqFlag, onHookMon, indicatorPolarity;
   reg thresholdSelLo, thresholdSelHi, fullWaveEnable, validationEnable;
   reg offHook, linkPowerdown, irqPolarity;
   reg [5:0] maxFreqCount, minFreqTimeout;
   reg [2:0] ringCheckWindow, validDelaySel;
   reg [3:0] ringEndTimeout;
   reg posRingFlag, negRingFlag, ringEnvelopeFlag;
   reg envPrev;
   reg [15:0] sampleHold;
   wire irqEvent;

   // ------------------------------------------------------------
   // threshold compare
   // ------------------------------------------------------------
   reg [15:0] thr;
   // two bits pick one of three levels; hi wins over lo
   always @* begin
      if (thresholdSelHi) begin
         thr = `RDV_THR_45V;
      end else if (thresholdSelLo) begin
         thr = `RDV_THR_21V;
      end else begin
         thr = `RDV_THR_15V;
      end
   end
   // compare the held word, so a link word that changes between valid
   // strobes never counts as a crossing
   wire signed [15:0] sv = sampleHold;
   wire signed [15:0] thrPos = thr;
   wire signed [15:0] thrNeg = -thr;
   wire abovePos = sv > thrPos;
   wire belowNeg = sv < thrNeg;
   // detection depends on rectifier mode
   wire detHit = abovePos | (fullWaveEnable & belowNeg);

   // ------------------------------------------------------------
   // fixed tick, independent of bus activity
   // ------------------------------------------------------------
   reg [15:0] tickCnt;
   reg tick;
   // last count of the divider, cut to the counter width on purpose
   wire [31:0] tickLast = `RDV_TICK_CYC - 1;
   always @(posedge clk) begin
      if (!rstn) begin
         tickCnt <= 16'h0000;
         tick <= 1'b0;
      end else if (tickCnt == tickLast[15:0]) begin
         tickCnt <= 16'h0000;
         tick <= 1'b1;
      end else begin
         tickCnt <= tickCnt + 16'h0001;
         tick <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // sample capture and polarity flags
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (!rstn) begin
         sampleHold <= 16'h0000;
         posRingFlag <= 1'b0;
         negRingFlag <= 1'b0;
      end else begin
         if (ringVoltageValid) begin
            sampleHold <= ringVoltage;
         end
         posRingFlag <= abovePos;
         negRingFlag <= belowNeg;
      end
   end

   // ------------------------------------------------------------
   // unqualified one-shot
   // ------------------------------------------------------------
   reg [12:0] oneShotCnt;
   reg oneShot;
   // the span fits in 13 bits; the upper bits are dropped on purpose
   wire [31:0] oneShotLoad = `RDV_ONESHOT_TICK;
   // retriggered by every detection, so a gap shorter than the span
   // keeps the envelope up through a cadence
   always @(posedge clk) begin
      if (!rstn || offHook) begin
         oneShotCnt <= 13'h0000;
         oneShot <= 1'b0;
      end else if (detHit) begin
         oneShotCnt <= oneShotLoad[12:0];
         oneShot <= 1'b1;
      end else if (tick && oneShotCnt != 13'h0000) begin
         oneShotCnt <= oneShotCnt - 13'h0001;
         if (oneShotCnt == 13'h0001) begin
            oneShot <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // validator
   // ------------------------------------------------------------
   // idle waits for a first crossing, freq checks the spacing of the
   // crossings, end waits for the ring to stop; the delay timer runs
   // inside end, so a short burst never reaches software
   localparam VS_IDLE = 2'h0;
   localparam VS_FREQ = 2'h1;
   localparam VS_END = 2'h2;
   reg [1:0] vState;
   reg lastPolPos; // side of the last crossing
   reg [7:0] intervalTk; // ticks since last crossing
   reg [7:0] checkTk; // ticks spent in tolerance
   reg [7:0] delayTk;
   reg delayDone;
   reg validEnv;
   // crossings count only when they alternate polarity
   wire crossPos = abovePos & ~lastPolPos;
   wire crossNeg = belowNeg & lastPolPos;
   wire crossing = crossPos | crossNeg;
   // interval too long means too low a frequency, too short too high
   wire tooSlow = intervalTk > {2'b00, minFreqTimeout};
   wire tooFast = intervalTk < {2'b00, maxFreqCount};
   // 3-bit and 4-bit fields scale to tick counts of 32 and 16
   wire [7:0] checkSpan = {ringCheckWindow, 5'h00};
   wire [7:0] endSpan = {ringEndTimeout, 4'h0};
   wire [7:0] delaySpan = {validDelaySel, 5'h00};
   always @(posedge clk) begin
      if (!rstn || offHook || !validationEnable) begin
         vState <= VS_IDLE;
         lastPolPos <= 1'b0;
         intervalTk <= 8'h00;
         checkTk <= 8'h00;
         delayTk <= 8'h00;
         delayDone <= 1'b0;
         validEnv <= 1'b0;
      end else begin
         if (crossing) begin
            lastPolPos <= crossPos;
            intervalTk <= 8'h00;
         end else if (tick && intervalTk != 8'hff) begin
            intervalTk <= intervalTk + 8'h01;
         end
         case (vState)
            VS_IDLE: begin
               checkTk <= 8'h00;
               if (crossing) begin
                  vState <= VS_FREQ;
               end
            end
            VS_FREQ: begin
               if ((crossing && tooFast) || tooSlow) begin
                  vState <= VS_IDLE;
               end else if (checkTk >= checkSpan) begin
                  vState <= VS_END;
                  delayTk <= 8'h00;
                  delayDone <= 1'b0;
               end else if (tick) begin
                  checkTk <= checkTk + 8'h01;
               end
            end
            VS_END: begin
               if (tick && !delayDone) begin
                  delayTk <= delayTk + 8'h01;
               end
               if (delayTk >= delaySpan) begin
                  delayDone <= 1'b1;
               end
               if (intervalTk > endSpan) begin
                  vState <= VS_IDLE;
                  validEnv <= 1'b0;
               end else if (delayDone) begin
                  validEnv <= 1'b1;
               end
            end
            default: begin
               vState <= VS_IDLE;
            end
         endcase
      end
   end

   // envelope seen by software and interrupt
   wire envSrc = validationEnable ? validEnv : oneShot;
   // interrupt edge select
   assign irqEvent = (envSrc & ~envPrev) |
      (bothEdgeIrq & ~envSrc & envPrev);

   // ------------------------------------------------------------
   // flags, interrupt, pins, stream
   // ------------------------------------------------------------
   wire indSrc = (validationEnable && !fullWaveEnable) ? validEnv :
      (validationEnable ? oneShot : detHit);
   wire ringOnStream = !linkPowerdown && !offHook && !onHookMon;
   reg [15:0] ringSample;
   // the msb follows the ring polarity in both modes, so software can
   // time ring cycles from the stream alone
   always @* begin
      if (abovePos) begin
         ringSample = `RDV_SAMPLE_MAX;
      end else if (fullWaveEnable && !belowNeg) begin
         ringSample = `RDV_SAMPLE_MID;
      end else begin
         ringSample = `RDV_SAMPLE_MIN;
      end
   end
   always @(posedge clk) begin
      if (!rstn) begin
         envPrev <= 1'b0;
         ringEnvelopeFlag <= 1'b0;
         ringIndicatorOut <= 1'b0;
         ringIndicatorOen <= 1'b1;
         sharedIrqOut <= 1'b0;
         txSampleOut <= 16'h0000;
      end else begin
         envPrev <= envSrc;
         ringEnvelopeFlag <= envSrc & ~offHook;
         // open drain: only the low level is driven; the enable carries
         // the level and the external pull sets the released state
         ringIndicatorOut <= 1'b0;
         ringIndicatorOen <= ~(indSrc ^ indicatorPolarity);
         sharedIrqOut <= ringIrqFlag ^ ~irqPolarity;
         txSampleOut <= ringOnStream ? ringSample : txAudio;
      end
   end

   // ------------------------------------------------------------
   // register writes and reads
   // ------------------------------------------------------------
   // one write port for every control bit; the status index only
   // takes the monitor bit, its ring flags are read only
   always @(posedge clk) begin
      if (!rstn) begin
         bothEdgeIrq <= 1'b0;
         ringIrqMask <= 1'b0;
         ringIrqFlag <= 1'b0;
         onHookMon <= 1'b0;
         indicatorPolarity <= 1'b0;
         thresholdSelLo <= 1'b0;
         thresholdSelHi <= 1'b0;
         fullWaveEnable <= 1'b0;
         validationEnable <= 1'b0;
         maxFreqCount <= 6'h00;
         minFreqTimeout <= 6'h00;
         ringCheckWindow <= 3'h0;
         validDelaySel <= 3'h0;
         ringEndTimeout <= 4'h0;
         offHook <= 1'b0;
         linkPowerdown <= 1'b0;
         irqPolarity <= 1'b0;
         regRdata <= 8'h00;
      end else begin
         if (regWr) begin
            case (regAddr)
               `RDV_REG_CTRL2: bothEdgeIrq <= regWdata[`RDV_BIT_BOTHEDGE];
               `RDV_REG_IRQMASK: ringIrqMask <= regWdata[`RDV_BIT_RINGIRQ];
               `RDV_REG_STATUS: onHookMon <= regWdata[`RDV_BIT_ONHMON];
               `RDV_REG_CTRL14: begin
                  indicatorPolarity <= regWdata[`RDV_BIT_INDPOL];
               end
               `RDV_REG_CTRL16: thresholdSelLo <= regWdata[`RDV_BIT_THRLO];
               `RDV_REG_CTRL17: thresholdSelHi <= regWdata[`RDV_BIT_THRHI];
               `RDV_REG_CTRL18: begin
                  fullWaveEnable <= regWdata[`RDV_BIT_FULLWAVE];
               end
               `RDV_REG_MAXFREQ: maxFreqCount <= regWdata[5:0];
               `RDV_REG_CHECK: begin
                  ringCheckWindow <= regWdata[2:0];
                  ringEndTimeout <= regWdata[6:3];
               end
               `RDV_REG_VALID: begin
                  minFreqTimeout <= regWdata[5:0];
                  validationEnable <= regWdata[`RDV_BIT_VALIDEN];
               end
               `RDV_REG_LINE: begin
                  offHook <= regWdata[`RDV_BIT_OFFHOOK];
                  linkPowerdown <= regWdata[`RDV_BIT_PWRDOWN];
                  validDelaySel <= regWdata[4:2];
               end
               `RDV_REG_IRQCFG: irqPolarity <= regWdata[`RDV_BIT_IRQPOL];
               default: begin
               end
            endcase
         end
         // a new event wins over a clearing write
         if (irqEvent && ringIrqMask) begin
            ringIrqFlag <= 1'b1;
         end else if (regWr && regAddr == `RDV_REG_IRQFLAG &&
                      !regWdata[`RDV_BIT_RINGIRQ]) begin
            ringIrqFlag <= 1'b0;
         end
         if (regRd) begin
            case (regAddr)
               `RDV_REG_CTRL2: regRdata <= {5'h00, bothEdgeIrq, 2'h0};
               `RDV_REG_IRQMASK: regRdata <= {ringIrqMask, 7'h00};
               `RDV_REG_IRQFLAG: regRdata <= {ringIrqFlag, 7'h00};
               `RDV_REG_STATUS: regRdata <= {4'h0, onHookMon,
                  ringEnvelopeFlag, negRingFlag, posRingFlag};
               `RDV_REG_CTRL14: regRdata <= {6'h00, indicatorPolarity, 1'b0};
               `RDV_REG_CTRL16: regRdata <= {7'h00, thresholdSelLo};
               `RDV_REG_CTRL17: regRdata <= {3'h0, thresholdSelHi, 4'h0};
               `RDV_REG_CTRL18: regRdata <= {6'h00, fullWaveEnable, 1'b0};
               `RDV_REG_MAXFREQ: regRdata <= {2'h0, maxFreqCount};
               `RDV_REG_CHECK: regRdata <= {1'b0, ringEndTimeout,
                  ringCheckWindow};
               `RDV_REG_VALID: regRdata <= {validationEnable, 1'b0,
                  minFreqTimeout};
               `RDV_REG_LINE: regRdata <= {3'h0, validDelaySel,
                  linkPowerdown, offHook};
               `RDV_REG_IRQCFG: regRdata <= {7'h00, irqPolarity};
               default: regRdata <= 8'h00;
            endcase
         end else begin
            regRdata <= 8'h00;
         end
      end
   end
endmodule

// [sim/rdv_ring_source.sv]
`timescale 1ns/1ps
// --------------------------------------------
// digitised ring voltage source on the link
// --------------------------------------------
module rdv_ring_source (
   // clock and reset
   input wire clk,
   input wire rstn,
   // commanded line level and pacing
   input wire [15:0] level,
   input wire slow,
   // samples toward the block
   output logic [15:0] ringVoltage,
   output logic ringVoltageValid
);
   logic [1:0] phase;

   // slow mode sends one sample in four; between samples the word is
   // scrambled so that nothing leans on a stale value
   always @(posedge clk) begin
      if (!rstn) begin
         phase <= 2'h0;
         ringVoltageValid <= 1'b0;
         ringVoltage <= 16'h0000;
      end else begin
         phase <= phase + 2'h1;
         if (!slow || phase == 2'h0) begin
            ringVoltageValid <= 1'b1;
            ringVoltage <= level;
         end else begin
            ringVoltageValid <= 1'b0;
            ringVoltage <= ~ringVoltage;
         end
      end
   end
endmodule

// [sim/rdv_ring_detect_validate_props.sv]
`timescale 1ns/1ps
// --------------------------------------------
// port checker for ring monitoring outputs
// --------------------------------------------
module rdv_checker (
   // clock and reset
   input wire clk,
   input wire rstn,
   // register port
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   input wire regWr,
   // ring input and outputs
   input wire [15:0] ringVoltage,
   input wire ringVoltageValid,
   input wire [15:0] txAudio,
   input wire [15:0] txSampleOut,
   input wire ringIndicatorOut,
   input wire ringIndicatorOen,
   input wire sharedIrqOut
);
   reg fw, pol, offH, pd, mon, valEn, irqPol;
   wire signed [15:0] v = ringVoltage;
   wire txOn = !offH && !pd && !mon;
   // levels clear of every threshold choice, so no threshold shadow
   wire bigPos = ringVoltageValid && v > 16'sd11520;
   wire bigNeg = ringVoltageValid && v < -16'sd11520;
   wire quiet = ringVoltageValid && v > -16'sd3584 && v < 16'sd3584;

   // shadow of control bits, updated on the same edge as the design
   always @(posedge clk) begin
      if (!rstn) begin
         {fw, pol, offH, pd, mon, valEn, irqPol} <= 7'h00;
      end else if (regWr) begin
         case (regAddr)
            8'h12: fw <= regWdata[1];
            8'h0e: pol <= regWdata[1];
            8'h18: valEn <= regWdata[7];
            8'h05: mon <= regWdata[3];
            8'h41: irqPol <= regWdata[0];
            8'h40: begin
               offH <= regWdata[0];
               pd <= regWdata[1];
            end
            default: ;
         endcase
      end
   end

   // --------------------------------------------
   // properties: sample at c0, outputs at c2
   // --------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_half_pos_max: assert property (
      (bigPos && !fw && txOn && !regWr) ##1 !regWr
      |=> txSampleOut == 16'h7fff) else $error("half-wave high sample");
   a_half_neg_min: assert property (
      (bigNeg && !fw && txOn && !regWr) ##1 !regWr
      |=> txSampleOut == 16'h8000) else $error("half-wave low sample");
   a_full_mid_code: assert property (
      (quiet && fw && txOn && !regWr) ##1 !regWr
      |=> txSampleOut == 16'h04cc) else $error("full-wave rest sample");
   a_full_neg_min: assert property (
      (bigNeg && fw && txOn && !regWr) ##1 !regWr
      |=> txSampleOut == 16'h8000) else $error("full-wave low sample");
   a_audio_pass: assert property (
      (!txOn && !regWr) ##1 (!regWr && $stable(txAudio))
      |=> txSampleOut == $past(txAudio)) else $error("audio not passed");
   a_ind_pos_drive: assert property (
      (bigPos && !pol && !valEn && !regWr) ##1 !regWr
      |=> !ringIndicatorOen) else $error("indicator not asserted");
   a_ind_quiet_idle: assert property (
      (quiet && !valEn && !regWr) ##1 !regWr
      |=> ringIndicatorOen == !pol) else $error("indicator not idle");
   a_ind_out_low: assert property (
      ringIndicatorOut == 1'b0) else $error("open-drain data not low");
   a_irq_clear_idle: assert property (
      (regWr && regAddr == 8'h04 && !regWdata[7]) ##1 !regWr
      |-> ##[0:2] sharedIrqOut == !irqPol) else $error("irq not cleared");
   a_reset_idle: assert property (disable iff (1'b0)
      !rstn |=> ringIndicatorOen && txSampleOut == 16'h0000)
      else $error("outputs not idle in reset");

   c_full_pos: cover property (bigPos && fw);
   c_full_neg: cover property (bigNeg && fw);
   c_irq_on: cover property (sharedIrqOut == irqPol);
endmodule

bind rdv_ring_detect_validate rdv_checker i_rdv_checker (
   .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .ringVoltage(ringVoltage),
   .ringVoltageValid(ringVoltageValid), .txAudio(txAudio),
   .txSampleOut(txSampleOut), .ringIndicatorOut(ringIndicatorOut),
   .ringIndicatorOen(ringIndicatorOen), .sharedIrqOut(sharedIrqOut)
);

// [sim/rdv_ring_detect_validate_tb.sv]
`timescale 1ns/1ps
module rdv_ring_detect_validate_tb;
   typedef struct packed {
      logic fw;
      logic lo;
      logic hi;
      logic [15:0] v;
      logic [1:0] fl;
      logic ind;
      logic [15:0] tx;
   } rdv_row_t;
   logic clk, rstn, regWr, regRd, slow, ringVoltageValid;
   logic ringIndicatorOut, ringIndicatorOen, sharedIrqOut;
   logic [7:0] regAddr, regWdata, regRdata, rdVal;
   logic [15:0] level, ringVoltage, txAudio, txSampleOut;
   logic [7:0] audA [3];
   logic [7:0] audD [3];
   rdv_row_t rows [11];
   int n_mismatch, n_compared, cyc;

   rdv_ring_detect_validate i_rdv_ring_detect_validate (
      .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .ringVoltage(ringVoltage), .ringVoltageValid(ringVoltageValid),
      .txAudio(txAudio), .txSampleOut(txSampleOut),
      .ringIndicatorOut(ringIndicatorOut),
      .ringIndicatorOen(ringIndicatorOen), .sharedIrqOut(sharedIrqOut));
   rdv_ring_source i_rdv_ring_source (
      .clk(clk), .rstn(rstn), .level(level), .slow(slow),
      .ringVoltage(ringVoltage), .ringVoltageValid(ringVoltageValid));

   // --------------------------------------------
   // clock, watchdog and shared tasks
   // --------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // the whole run needs well under a thousand cycles
   initial begin
      forever begin
         @(posedge clk);
         cyc++;
         if (cyc == 5000) begin
            n_mismatch++;
            end_sim();
         end
      end
   end

   task end_sim();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task chk(input string what, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task wr(input logic [7:0] a, d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask

   // slow pacing gives a fresh sample only every fourth cycle
   task setv(input logic [15:0] v, input logic s);
      @(posedge clk);
      level <= v;
      slow <= s;
      tick(12);
   endtask

   // --------------------------------------------
   // main sequence
   // --------------------------------------------
   initial begin
      rstn = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      regWdata = 8'h00;
      level = 16'h0000;
      slow = 1'b0;
      txAudio = 16'h1234;
      rows = '{'{1'b0, 1'b0, 1'b0, 16'h0f01, 2'b01, 1'b1, 16'h7fff},
               '{1'b0, 1'b0, 1'b0, 16'h0f00, 2'b00, 1'b0, 16'h8000},
               '{1'b0, 1'b0, 1'b0, 16'h8000, 2'b10, 1'b0, 16'h8000},
               '{1'b1, 1'b0, 1'b0, 16'hf0ff, 2'b10, 1'b1, 16'h8000},
               '{1'b1, 1'b0, 1'b0, 16'h0100, 2'b00, 1'b0, 16'h04cc},
               '{1'b1, 1'b0, 1'b0, 16'h7000, 2'b01, 1'b1, 16'h7fff},
               '{1'b0, 1'b1, 1'b0, 16'h1500, 2'b00, 1'b0, 16'h8000},
               '{1'b0, 1'b1, 1'b0, 16'h1501, 2'b01, 1'b1, 16'h7fff},
               '{1'b0, 1'b0, 1'b1, 16'h2d00, 2'b00, 1'b0, 16'h8000},
               '{1'b0, 1'b1, 1'b1, 16'h2d01, 2'b01, 1'b1, 16'h7fff},
               '{1'b1, 1'b0, 1'b1, 16'hd2ff, 2'b10, 1'b1, 16'h8000}};
      audA = '{8'h40, 8'h40, 8'h05};
      audD = '{8'h01, 8'h02, 8'h08};
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      tick(2);
      chk("oen after reset", ringIndicatorOen, 16'h0001);
      chk("irq pin idle", sharedIrqOut, 16'h0001);
      rd(8'h12, rdVal);
      chk("full-wave default", rdVal[1], 16'h0000);
      // threshold choice, detector mode and level per row
      foreach (rows[i]) begin
         wr(8'h12, {6'h00, rows[i].fw, 1'b0});
         wr(8'h10, {7'h00, rows[i].lo});
         wr(8'h11, {3'h0, rows[i].hi, 4'h0});
         setv(rows[i].v, 1'b0);
         rd(8'h05, rdVal);
         chk("ring flags", rdVal[1:0], rows[i].fl);
         chk("indicator oen", ringIndicatorOen, !rows[i].ind);
         chk("ring sample", txSampleOut, rows[i].tx);
      end
      // off-hook drops the envelope; every blocker hands tx to audio
      wr(8'h40, 8'h01);
      setv(16'h0100, 1'b0);
      rd(8'h05, rdVal);
      chk("envelope off-hook", rdVal[2], 16'h0000);
      foreach (audA[i]) begin
         wr(audA[i], audD[i]);
         tick(4);
         chk("audio pass", txSampleOut, txAudio);
         wr(audA[i], 8'h00);
      end
      tick(4);
      chk("ring stream back", txSampleOut, 16'h04cc);
      // masked envelope rise with a slow link, then clear and flip pin
      wr(8'h03, 8'h80);
      setv(16'h3000, 1'b1);
      chk("irq pin active", sharedIrqOut, 16'h0000);
      rd(8'h04, rdVal);
      chk("irq flag", rdVal[7], 16'h0001);
      rd(8'h05, rdVal);
      chk("envelope set", rdVal[2], 16'h0001);
      wr(8'h04, 8'h00);
      tick(4);
      chk("irq cleared", sharedIrqOut, 16'h0001);
      wr(8'h41, 8'h01);
      tick(4);
      chk("irq polarity", sharedIrqOut, 16'h0000);
      wr(8'h0e, 8'h02);
      tick(4);
      chk("indicator high", ringIndicatorOen, 16'h0001);
      setv(16'h0000, 1'b0);
      chk("indicator idle", ringIndicatorOen, 16'h0000);
      // validator with all fields zero: envelope follows at once
      wr(8'h12, 8'h00);
      wr(8'h0e, 8'h00);
      wr(8'h18, 8'h80);
      setv(16'h3000, 1'b0);
      rd(8'h05, rdVal);
      chk("validated envelope", rdVal[2], 16'h0001);
      chk("validated indicator", ringIndicatorOen, 16'h0000);
      rd(8'h04, rdVal);
      chk("validated irq flag", rdVal[7], 16'h0001);
      // both-edge interrupt: off-hook drops the envelope, which must fire
      wr(8'h04, 8'h00);
      wr(8'h02, 8'h04);
      wr(8'h40, 8'h01);
      tick(2);
      rd(8'h04, rdVal);
      chk("falling-edge irq", rdVal[7], 16'h0001);
      chk("irq pin high", sharedIrqOut, 16'h0001);
      wr(8'h7f, 8'h5a);
      rd(8'h7f, rdVal);
      chk("unmapped read", rdVal, 16'h0000);
      end_sim();
   end
endmodule
